// File: design/rsc_config_bank.sv
// Range registers and 32-entry sequencer stack for a dual sampling ADC.
// Assumes host words arrive synchronous to clk, one per host_word_valid.
// How it works
// RQ1: Two-bit range codes: 00/11 10V, 01 2V5, 10 5V.
// RQ2: Every range field resets to three.
// RQ3: Lowest group input in [1:0], then [3:2], [5:4].
// RQ4: B low range register at 0x06, reset 0x00FF.
// RQ5: B high range register at 0x07, reset 0x00FF.
// RQ6: Word [15:9] address, bit 8 reserved zero; the code decodes the address from [14:9] and takes bit 15 as the write flag.
// RQ7: Address bit five selects one of 32 stack entries.
// RQ8: Stack at 0x20..0x3F, default pattern else zero.
// RQ9: Each entry names an A and B input pair.
// RQ10: Sequencer starts at first entry, wraps after 32nd.
// RQ11: End bit set returns sequencer to first entry.
// RQ12: Default entries pair inputs zero through seven.
// RQ13: Full and partial reset reinitialise the stack.
// RQ14: Entry [7:4] B select, [3:0] A select.
// RQ15: Select 1011 yields 0xAAAA on A, 0x5555 on B.
// RQ16: First eight entries default, eighth marked end.
// RQ17: Fourth range field sits in bits 7 and 6.
// RQ18: Pointer advances one per completed pair conversion.
`timescale 1ns/1ns
`default_nettype none
module rsc_config_bank
  import rsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        partial_reset,
  input  wire logic        host_word_valid,
  input  wire logic [15:0] host_word,
  input  wire logic        pair_done,
  output logic             read_valid,
  output logic [15:0]      read_word,
  output logic [7:0]       a_range_high_inputs,
  output logic [7:0]       b_range_low_inputs,
  output logic [7:0]       b_range_high_inputs,
  output logic [4:0]       entry_pointer,
  output logic [3:0]       a_side_input_select,
  output logic [3:0]       b_side_input_select,
  output logic             sequence_last_entry_flag,
  output logic [1:0]       b_current_range,
  output logic [15:0]      a_test_word,
  output logic [15:0]      b_test_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Word decode

  wire        clear_all = !reset_n || partial_reset;
  wire [5:0]  word_addr = host_word[14:ADDR_LSB];
  wire        word_wr   = host_word_valid && host_word[WORD_WRITE_BIT];
  wire        word_rd   = host_word_valid && !host_word[WORD_WRITE_BIT];
  wire        stack_hit = host_word[STACK_SEL_BIT];                 // [RQ7]
  wire [4:0]  stack_idx = host_word[13:ADDR_LSB];
  wire        wr_a_high = word_wr && (word_addr == ADDR_A_RANGE_HIGH);
  wire        wr_b_low  = word_wr && (word_addr == ADDR_B_RANGE_LOW);  // [RQ4]
  wire        wr_b_high = word_wr && (word_addr == ADDR_B_RANGE_HIGH); // [RQ5]
  wire        wr_stack  = word_wr && stack_hit;                      // [RQ8]

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer stack storage

  logic [8:0] stack_mem [ENTRY_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < ENTRY_COUNT; gi++)
    begin : g_entry
      // Entries 0..7 pair equal inputs, entry 7 closes the loop
      localparam logic [3:0] IDX = 4'(gi);
      localparam logic [8:0] DEF = (gi < DEFAULT_PAIRS) ?
        {(gi == DEFAULT_PAIRS - 1), IDX, IDX} : ENTRY_RESET; // [RQ12] [RQ16]
      always_ff @(posedge clk)
      begin
        if (clear_all)
          stack_mem[gi] <= DEF;                                  // [RQ13]
        else if (wr_stack && stack_idx == 5'(gi))
          stack_mem[gi] <= host_word[8:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Range registers

  always_ff @(posedge clk)
  begin
    if (clear_all)
    begin
      a_range_high_inputs <= RANGE_RESET;                           // [RQ2]
      b_range_low_inputs  <= RANGE_RESET;
      b_range_high_inputs <= RANGE_RESET;
    end
    else
    begin
      if (wr_a_high)
        a_range_high_inputs <= host_word[7:0];
      if (wr_b_low)
        b_range_low_inputs <= host_word[7:0];                       // [RQ4]
      if (wr_b_high)
        b_range_high_inputs <= host_word[7:0];                      // [RQ5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire [7:0] rd_range =
    (word_addr == ADDR_A_RANGE_HIGH) ? a_range_high_inputs :
    (word_addr == ADDR_B_RANGE_LOW)  ? b_range_low_inputs  :
    (word_addr == ADDR_B_RANGE_HIGH) ? b_range_high_inputs : 8'h00;
  // Bit 8 of range words is reserved and reads zero
  wire [8:0] rd_data = stack_hit ? stack_mem[stack_idx] : {1'b0, rd_range};

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      read_valid <= 1'b0;
      read_word  <= 16'h0000;
    end
    else
    begin
      read_valid <= word_rd;
      if (word_rd)
        read_word <= {1'b0, word_addr, rd_data};                    // [RQ6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer pointer and current pair

  wire [8:0] cur_entry = stack_mem[entry_pointer];
  wire       cur_last  = cur_entry[END_BIT];
  wire [3:0] cur_a     = cur_entry[3:A_SEL_LSB];                    // [RQ14]
  wire [3:0] cur_b     = cur_entry[7:B_SEL_LSB];                    // [RQ9]
  // Wraps to zero naturally after entry 31
  wire [4:0] next_pointer = cur_last ? 5'h00 :                      // [RQ11]
                            5'(entry_pointer + 5'h01);              // [RQ10]
  wire [7:0] b_group = cur_b[2] ? b_range_high_inputs : b_range_low_inputs;
  // Range field k of a group sits at [2k+1:2k]
  wire [1:0] b_field = b_group[{cur_b[1:0], 1'b0} +: 2];     // [RQ3] [RQ17]

  always_ff @(posedge clk)
  begin
    if (clear_all)
      entry_pointer <= 5'h00;                                       // [RQ10]
    else if (pair_done)
      entry_pointer <= next_pointer;                                // [RQ18]
  end

  always_ff @(posedge clk)
  begin
    if (clear_all)
    begin
      a_side_input_select      <= 4'h0;
      b_side_input_select      <= 4'h0;
      sequence_last_entry_flag <= 1'b0;
      b_current_range          <= RANGE_FIELD_RESET;
      a_test_word              <= 16'h0000;
      b_test_word              <= 16'h0000;
    end
    else
    begin
      a_side_input_select      <= cur_a;                            // [RQ9]
      b_side_input_select      <= cur_b;
      sequence_last_entry_flag <= cur_last;
      // Only analog inputs carry a range; monitors keep the 10 V code
      b_current_range <= cur_b[3] ? RANGE_10V_ALT : b_field;        // [RQ1]
      a_test_word <= (cur_a == SEL_SELF_TEST) ?                     // [RQ15]
                     TEST_WORD_A : 16'h0000;
      b_test_word <= (cur_b == SEL_SELF_TEST) ?                     // [RQ15]
                     TEST_WORD_B : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_stack_write;
    wr_stack && !partial_reset;
  endsequence

  AST_RANGE_RESET: assert property ( // [RQ2]
    partial_reset |=> b_range_low_inputs == RANGE_RESET
                      && b_range_high_inputs == RANGE_RESET)
    else $error("Range registers not restored");
  AST_B_LOW_WRITE: assert property ( // [RQ4]
    wr_b_low && !partial_reset |=> b_range_low_inputs == $past(host_word[7:0]))
    else $error("B low range write lost");
  AST_B_HIGH_WRITE: assert property ( // [RQ5]
    wr_b_high && !partial_reset
      |=> b_range_high_inputs == $past(host_word[7:0]))
    else $error("B high range write lost");
  AST_READ_FORMAT: assert property ( // [RQ6]
    word_rd |=> read_valid && read_word[15:9] == $past(host_word[15:9])
                && (read_word[8] == 1'b0 || $past(stack_hit)))
    else $error("Read word address or reserved bit wrong");
  AST_STACK_WRITE: assert property ( // [RQ8]
    s_stack_write |=> stack_mem[$past(stack_idx)] == $past(host_word[8:0]))
    else $error("Stack entry write lost");
  AST_STACK_DEFAULT: assert property ( // [RQ16]
    partial_reset |=> stack_mem[7] == 9'h177 && stack_mem[8] == ENTRY_RESET
                      && stack_mem[0] == 9'h000 && stack_mem[3] == 9'h033)
    else $error("Stack default pattern wrong");
  AST_POINTER_STEP: assert property ( // [RQ18]
    pair_done && !partial_reset && !cur_last && entry_pointer != 5'h1F
      |=> entry_pointer == $past(entry_pointer) + 5'h01)
    else $error("Pointer did not advance by one");
  AST_END_WRAP: assert property ( // [RQ11]
    pair_done && !partial_reset && cur_last |=> entry_pointer == 5'h00)
    else $error("End entry did not return to first");
  AST_HOLD: assert property ( // [RQ10]
    !pair_done && !partial_reset |=> $stable(entry_pointer))
    else $error("Pointer moved without a conversion");
  AST_SELF_TEST: assert property ( // [RQ15]
    cur_a == SEL_SELF_TEST && !partial_reset ##1 $stable(entry_pointer)
      |-> a_test_word == TEST_WORD_A)
    else $error("Self-test pattern missing");

  ////////////////////////////////////////////////////////////////////////////
  // Register bus checks

  // Any range register write not overridden by a clear
  sequence s_range_write;
    (wr_a_high || wr_b_low || wr_b_high) && !partial_reset;
  endsequence

  AST_A_HIGH_WRITE: assert property ( // [RQ3]
    wr_a_high && !partial_reset
      |=> a_range_high_inputs == $past(host_word[7:0]))
    else $error("A high range write lost");
  AST_RESERVED_ZERO: assert property ( // [RQ6]
    word_rd && !stack_hit |=> read_word[RESERVED_BIT] == 1'b0)
    else $error("Reserved bit of a range word not zero");
  AST_READ_PULSE: assert property ( // [RQ6]
    read_valid |-> $past(word_rd))
    else $error("Read answer without a read word");
  AST_READ_HOLD: assert property ( // [RQ6]
    !word_rd |=> $stable(read_word))
    else $error("Read word changed without a read");
  // Stack and range spaces never touch each other
  AST_STACK_SPACE: assert property ( // [RQ7]
    word_wr && word_addr >= ADDR_STACK_FIRST && word_addr <= ADDR_STACK_LAST
      |-> wr_stack && !wr_b_low && !wr_b_high)
    else $error("Stack address not routed to the stack");
  AST_STACK_NO_RANGE: assert property ( // [RQ7]
    s_stack_write |=> $stable(b_range_low_inputs)
                      && $stable(b_range_high_inputs))
    else $error("Stack write disturbed a range register");
  AST_RANGE_NO_STACK: assert property ( // [RQ8]
    s_range_write |=> $stable(stack_mem[0]) && $stable(stack_mem[31]))
    else $error("Range write disturbed the stack");

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer checks

  // Cycles with a partial reset are left to the reset checks
  // Last entry of the stack without its end bit set
  sequence s_pair_wrap;
    pair_done && !partial_reset && !cur_last && entry_pointer == 5'h1F;
  endsequence

  AST_POINTER_WRAP: assert property ( // [RQ10]
    s_pair_wrap |=> entry_pointer == 5'h00)
    else $error("Pointer did not wrap after the last entry");
  AST_POINTER_CLEAR: assert property ( // [RQ13]
    partial_reset |=> entry_pointer == 5'h00)
    else $error("Partial reset left the pointer set");
  AST_PAIR_SELECT: assert property ( // [RQ9] [RQ14]
    !partial_reset |=> a_side_input_select == $past(cur_entry[3:0])
                       && b_side_input_select == $past(cur_entry[7:4]))
    else $error("Selected pair does not match the entry");
  AST_LAST_FLAG: assert property ( // [RQ11]
    !partial_reset |=> sequence_last_entry_flag == $past(cur_entry[END_BIT]))
    else $error("End flag does not match the entry");
  AST_DEFAULT_LAST: assert property ( // [RQ16]
    partial_reset |=> stack_mem[6] == 9'h066 && stack_mem[31] == ENTRY_RESET)
    else $error("Default end entry misplaced");
  AST_B_SELF_TEST: assert property ( // [RQ15]
    cur_b == SEL_SELF_TEST && !partial_reset |=> b_test_word == TEST_WORD_B)
    else $error("B self-test pattern missing");
  // Pattern words stay zero for ordinary inputs
  AST_TEST_IDLE: assert property ( // [RQ15]
    cur_a != SEL_SELF_TEST && cur_b != SEL_SELF_TEST && !partial_reset
      |=> a_test_word == 16'h0000 && b_test_word == 16'h0000)
    else $error("Self-test pattern outside a self-test entry");
  AST_MONITOR_RANGE: assert property ( // [RQ1]
    cur_b[3] && !partial_reset |=> b_current_range == RANGE_10V_ALT)
    else $error("Monitor input range not the 10 V code");
  // Field order within a group, first and last input
  AST_B_FIRST_FIELD: assert property ( // [RQ3]
    cur_b == 4'h0 && !partial_reset
      |=> b_current_range == $past(b_range_low_inputs[1:0]))
    else $error("Range of B input zero taken from wrong field");
  AST_B_LAST_FIELD: assert property ( // [RQ17]
    cur_b == 4'h7 && !partial_reset
      |=> b_current_range == $past(b_range_high_inputs[7:6]))
    else $error("Range of B input seven taken from wrong field");

endmodule
`default_nettype wire

// File: pkg/rsc_pkg.sv
// Constants for the range and sequencer configuration bank.
// Assumes 16-bit host words: bit 15 write flag, [14:9] address, [8:0] data.
package rsc_pkg;
  localparam int          WORD_W        = 16;
  localparam int          ENTRY_COUNT   = 32;
  localparam int          DEFAULT_PAIRS = 8;
  // Host word layout
  localparam int          WORD_WRITE_BIT = 15;
  localparam int          ADDR_MSB       = 15;
  localparam int          ADDR_LSB       = 9;
  localparam int          STACK_SEL_BIT  = 14;
  localparam int          RESERVED_BIT   = 8;
  // Register offsets (six-bit address in [14:9])
  localparam logic [5:0]  ADDR_A_RANGE_HIGH = 6'h05;
  localparam logic [5:0]  ADDR_B_RANGE_LOW  = 6'h06;
  localparam logic [5:0]  ADDR_B_RANGE_HIGH = 6'h07;
  localparam logic [5:0]  ADDR_STACK_FIRST  = 6'h20;
  localparam logic [5:0]  ADDR_STACK_LAST   = 6'h3F;
  // Reset values
  localparam logic [7:0]  RANGE_RESET   = 8'hFF;
  localparam logic [1:0]  RANGE_FIELD_RESET = 2'h3;
  localparam logic [8:0]  ENTRY_RESET   = 9'h000;
  // Entry fields
  localparam int          END_BIT       = 8;
  localparam int          B_SEL_LSB     = 4;
  localparam int          A_SEL_LSB     = 0;
  // Input select and range codes
  localparam logic [3:0]  SEL_SUPPLY    = 4'h8;
  localparam logic [3:0]  SEL_REGULATOR = 4'h9;
  localparam logic [3:0]  SEL_SELF_TEST = 4'hB;
  localparam logic [1:0]  RANGE_10V     = 2'h0;
  localparam logic [1:0]  RANGE_2V5     = 2'h1;
  localparam logic [1:0]  RANGE_5V      = 2'h2;
  localparam logic [1:0]  RANGE_10V_ALT = 2'h3;
  localparam logic [15:0] TEST_WORD_A   = 16'hAAAA;
  localparam logic [15:0] TEST_WORD_B   = 16'h5555;
endpackage

// File: sim/rsc_host_model.sv
// Host controller model: sends write and read words to the bank.
// Assumes words launch on the falling edge of clk.
`timescale 1ns/1ns
`default_nettype none
module rsc_host_model
  import rsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        read_valid,
  input  wire logic [15:0] read_word,
  output logic             host_word_valid,
  output logic [15:0]      host_word
);
  initial
  begin
    host_word_valid = 1'b0;
    host_word       = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic put(input logic wr, input logic [5:0] a,
                     input logic [8:0] d);
    @(negedge clk);
    host_word_valid = 1'b1;
    host_word       = {wr, a, d};
    @(negedge clk);
    host_word_valid = 1'b0;
    // Released word never shows the old value
    host_word       = ~host_word;
  endtask

  task automatic get(input logic [5:0] a, output logic [15:0] q);
    int n;
    put(1'b0, a, 9'h000);
    n = 0;
    while (read_valid !== 1'b1 && n < 3)
    begin
      @(negedge clk);
      n++;
    end
    q = (read_valid === 1'b1) ? read_word : 16'hDEAD;
  endtask
endmodule
`default_nettype wire

// File: sim/test_range_and_sequencer_config.sv
// Bench for the range and stack bank, host model on the word port.
// Assumes inputs change on the falling edge of a 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module test_range_and_sequencer_config import rsc_pkg::*;;
  typedef struct packed {logic [5:0] a; logic [8:0] d; logic [15:0] e;}
    rsc_row_t;
  logic        clk = 1'b0;
  logic        reset_n, partial_reset, pair_done, hv, rv, last;
  logic [15:0] hw, rw, rd, ta, tb;
  logic [7:0]  rah, rbl, rbh;
  logic [4:0]  ptr;
  logic [3:0]  as, bs;
  logic [1:0]  br;
  int          error_cnt, total_checks, p;
  rsc_row_t    rows [6];

  always #10 clk = ~clk;
  rsc_host_model host_u (.clk(clk), .read_valid(rv), .read_word(rw),
    .host_word_valid(hv), .host_word(hw));
  rsc_config_bank dut_u (.clk(clk), .reset_n(reset_n),
    .partial_reset(partial_reset), .host_word_valid(hv), .host_word(hw),
    .pair_done(pair_done), .read_valid(rv), .read_word(rw),
    .a_range_high_inputs(rah), .b_range_low_inputs(rbl),
    .b_range_high_inputs(rbh), .entry_pointer(ptr),
    .a_side_input_select(as), .b_side_input_select(bs),
    .sequence_last_entry_flag(last), .b_current_range(br),
    .a_test_word(ta), .b_test_word(tb));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    host_u.get(a, rd);
    chk(rd, e);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Entry 7 is either the default end entry or a self-test pair
  task automatic walk(input int n, input logic alt);
    logic [8:0]  e;
    logic [15:0] r;
    repeat (n)
    begin
      @(negedge clk) pair_done = 1'b1;
      @(negedge clk) pair_done = 1'b0;
      p = alt ? (p + 1) % 32 : (p == 7 ? 0 : p + 1);
      @(negedge clk);
      e = p < 7 ? {1'b0, p[3:0], p[3:0]} : p > 7 ? 9'h000 :
          alt ? 9'h0BB : 9'h177;
      // B ranges: high group 0x1B, low group 0xE4
      r = 16'h1BE4 >> (2 * e[6:4]);
      chk(16'(ptr), 16'(p));
      chk({7'h00, last, bs, as}, {7'h00, e});
      chk(16'(br), e[7] ? 16'h0003 : 16'(r[1:0]));
      chk(ta, e[3:0] == SEL_SELF_TEST ? TEST_WORD_A : 16'h0000);
      chk(tb, e[7:4] == SEL_SELF_TEST ? TEST_WORD_B : 16'h0000);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    partial_reset = 1'b0;
    pair_done = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    p = 0;
    rows = '{'{6'h06, 9'h1E4, 16'h0CE4}, '{6'h07, 9'h01B, 16'h0E1B},
             '{6'h05, 9'h0C6, 16'h0AC6}, '{6'h20, 9'h1BA, 16'h41BA},
             '{6'h3F, 9'h123, 16'h7F23}, '{6'h10, 9'h155, 16'h2000}};
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    chk({rah, rbl}, 16'hFFFF);
    chk(16'(rbh), 16'h00FF);
    for (int k = 0; k < 10; k++)
      rdchk(6'(32 + k), {1'b0, 6'(32 + k), k == 7,
            k < 8 ? 8'(k * 17) : 8'h00});
    $display("reset test done");
    foreach (rows[i])
    begin
      host_u.put(1'b1, rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk({rah, rbl}, 16'hC6E4);
    chk(16'(rbh), 16'h001B);
    $display("register table test done");
    @(negedge clk) partial_reset = 1'b1;
    @(negedge clk) partial_reset = 1'b0;
    chk({rbh, rbl}, 16'hFFFF);
    chk(16'(ptr), 16'h0000);
    rdchk(6'h20, 16'h4000);
    rdchk(6'h27, 16'h4F77);
    rdchk(6'h3F, 16'h7E00);
    $display("partial reset test done");
    host_u.put(1'b1, 6'h06, 9'h0E4);
    host_u.put(1'b1, 6'h07, 9'h01B);
    walk(8, 1'b0);
    host_u.put(1'b1, 6'h27, 9'h0BB);
    walk(33, 1'b1);
    $display("sequencer test done");
    @(negedge clk) reset_n = 1'b0;
    @(negedge clk) reset_n = 1'b1;
    chk({rbh, rbl}, 16'hFFFF);
    chk({rw[15:5], ptr}, 16'h0000);
    rdchk(6'h27, 16'h4F77);
    $display("full reset test done");
    summarize();
  end

  // Whole run is under two hundred cycles; this is far beyond it
  initial
  begin
    #1_000_000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
